// ===== rtl/bpw_pkg.sv
package bpw_pkg;

  // pin index layout: port A bits 0..7, B single bits 8..14, D single bits 15..16
  localparam int NUM_PINS = 17;
  localparam int NUM_A = 8;
  localparam int B_LO = 8;
  localparam int D_LO = 15;

  // data memory addresses of the port registers
  localparam logic [7:0] ADDR_PA_DAT = 8'h12;
  localparam logic [7:0] ADDR_PA_DIR = 8'h13;
  localparam logic [7:0] ADDR_PB_DAT = 8'h20;
  localparam logic [7:0] ADDR_PB_DIR = 8'h28;
  localparam logic [7:0] ADDR_PD_DAT = 8'h30;
  localparam logic [7:0] ADDR_PD_DIR = 8'h32;
  localparam logic [7:0] ADDR_FLAG = 8'h16;

  // bit positions
  localparam int FLAG_AXIS1_BIT = 6;
  localparam int FLAG_AXIS2_BIT = 7;
  localparam int PIN_TIMER = 2;
  localparam int PIN_AXIS1 = 4;
  localparam int PIN_AXIS2 = 5;

  // values after reset
  localparam logic [16:0] RST_DATA = 17'h1ffff;
  localparam logic [16:0] RST_DIR = 17'h1ffff;
  localparam logic [16:0] RST_PINS = 17'h1ffff;
  localparam logic [1:0] RST_FLAGS = 2'h0;
  localparam logic [7:0] RST_RDATA = 8'h00;

  typedef enum logic [1:0] {
    BPW_RUN = 2'b00,
    BPW_HALT = 2'b01,
    BPW_WAKE = 2'b11
  } bpw_pwr_t;

  typedef struct packed {
    logic wr;
    logic rd;
    logic bit_op;
    logic bit_set;
    logic [2:0] bit_sel;
    logic [7:0] addr;
    logic [7:0] wdata;
  } bpw_cmd_t;

endpackage : bpw_pkg

// ===== rtl/bpw_sync.sv
`timescale 1ns/100ps
`default_nettype none

module bpw_sync #(
  parameter int W = 17,
  parameter logic [W-1:0] RST_VAL = '1
) (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);

  logic [W-1:0] meta_ff;

  // first stage feeds only the second stage
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      meta_ff <= RST_VAL;
      q <= RST_VAL;
    end else begin
      meta_ff <= d;
      q <= meta_ff;
    end
  end

endmodule : bpw_sync

`default_nettype wire

// ===== rtl/bpw_port.sv
// How it works
// [RULE1] 17 lines: 8-bit port A, seven B bits, two D bits, each data+direction.
// [RULE2] direction one is input, zero is CMOS output; changeable any time. The code takes direction writes only in the run state.
// [RULE3] written data sits in the output latch until the next write.
// [RULE4] inputs are not latched; pin level sampled in the read cycle.
// [RULE5] reading an output pin returns the data latch, not the pin.
// [RULE6] reset sets all data and direction registers to ones.
// [RULE7] pin turned to output before any write drives high.
// [RULE8] bit set/clear reads whole port, modifies one bit, writes all back.
// [RULE9] pull-high only on input pins, presence fixed by option input.
// [RULE10] option-selected port A pins wake from power-down on falling edge.
// [RULE11] while halted the clock stays stopped until a valid wake edge.
// [RULE12] the two axis pins, when enabled, wake on both edges.
// [RULE13] axis wake sets bit 6 or bit 7 of register 16H.
// [RULE14] reading an axis wake flag clears it.
// [RULE15] plain I/O use of timer pin needs internal-clock timer mode.
// [RULE16] external count needs event mode and the timer pin as input.
// [RULE17] axis flags clear at reset and set only while halted.
`timescale 1ns/100ps
`default_nettype none

module bpw_port (
  input wire logic clk,
  input wire logic rst_b,
  input wire bpw_pkg::bpw_cmd_t cmd,
  input wire logic halt_req,
  input wire logic [16:0] pin_in,
  input wire logic [16:0] pull_opt,
  input wire logic [7:0] wake_opt,
  input wire logic [1:0] axis_both_opt,
  output logic [7:0] rd_data,
  output logic [16:0] pin_out,
  output logic [16:0] pin_oe_b,
  output logic [16:0] pull_on,
  output logic timer_event_input,
  output logic power_down,
  output logic clk_run,
  output logic wake_pulse,
  output logic [1:0] axis_flags
);

  logic [16:0] pin_sync;
  logic [16:0] dat_ff;
  logic [16:0] dir_ff;
  logic [16:0] nxt_dat;
  logic [16:0] nxt_dir;
  logic [7:0] prev_a_ff;
  logic [1:0] flag_ff;
  logic [1:0] nxt_flag;
  logic [7:0] rd_data_ff;
  logic [16:0] pull_ff;
  logic pd_ff;
  logic run_ff;
  logic wake_ff;
  bpw_pkg::bpw_pwr_t state_ff;
  bpw_pkg::bpw_pwr_t nxt_state;

  // pins cross into the clock domain before anything reads them
  bpw_sync #(
    .W(17),
    .RST_VAL(bpw_pkg::RST_PINS)
  ) u_sync (
    .clk(clk),
    .rst_b(rst_b),
    .d(pin_in),
    .q(pin_sync)
  );

  // access decode
  wire active = (state_ff == bpw_pkg::BPW_RUN);
  wire do_wr = active & (cmd.wr | cmd.bit_op);
  wire do_rd = active & (cmd.rd | cmd.bit_op);
  wire [16:0] hit_dat;
  wire [16:0] hit_dir;
  wire [16:0] pin_val;
  wire [16:0] wbit;
  wire [7:0] wval;
  wire hit_flag = (cmd.addr == bpw_pkg::ADDR_FLAG);

  genvar gi;
  generate
    for (gi = 0; gi < bpw_pkg::NUM_PINS; gi++) begin : g_pin
      localparam logic [7:0] A_DAT = (gi < bpw_pkg::B_LO) ? bpw_pkg::ADDR_PA_DAT :
        (gi < bpw_pkg::D_LO) ? bpw_pkg::ADDR_PB_DAT + 8'(gi - bpw_pkg::B_LO) :
        bpw_pkg::ADDR_PD_DAT + 8'(gi - bpw_pkg::D_LO);
      localparam logic [7:0] A_DIR = (gi < bpw_pkg::B_LO) ? bpw_pkg::ADDR_PA_DIR :
        (gi < bpw_pkg::D_LO) ? bpw_pkg::ADDR_PB_DIR + 8'(gi - bpw_pkg::B_LO) :
        bpw_pkg::ADDR_PD_DIR + 8'(gi - bpw_pkg::D_LO);
      assign hit_dat[gi] = (cmd.addr == A_DAT); // see [RULE1]
      assign hit_dir[gi] = (cmd.addr == A_DIR); // see [RULE1]
      // output pins read back their latch, input pins the live level
      assign pin_val[gi] = dir_ff[gi] ? pin_sync[gi] : dat_ff[gi]; // see [RULE4] see [RULE5]
      assign wbit[gi] = wval[(gi < bpw_pkg::NUM_A) ? gi : 0];
    end
  endgenerate

  // single-bit registers answer in bit 0, upper bits read zero
  wire sb_dat = |(hit_dat[16:8] & pin_val[16:8]);
  wire sb_dir = |(hit_dir[16:8] & dir_ff[16:8]);
  wire hit_any = hit_dat[0] | hit_dir[0] | hit_flag | (|hit_dat[16:8]) | (|hit_dir[16:8]);

  wire [7:0] rd_mux = hit_dat[0] ? pin_val[7:0] :
                      hit_dir[0] ? dir_ff[7:0] :
                      hit_flag ? {flag_ff, 6'h00} :
                      hit_any ? {7'h00, sb_dat | sb_dir} : 8'h00;

  // bit op: whole register read, one bit changed, everything written back;
  // on input pins this copies the pin level into the latch, as on the real part
  wire [7:0] bit_mask = 8'h01 << cmd.bit_sel;
  wire [7:0] rmw_val = cmd.bit_set ? (rd_mux | bit_mask) : (rd_mux & ~bit_mask); // see [RULE8]
  assign wval = cmd.bit_op ? rmw_val : cmd.wdata; // see [RULE8]

  wire [16:0] wr_dat = hit_dat & {17{do_wr}};
  wire [16:0] wr_dir = hit_dir & {17{do_wr}};

  assign nxt_dat = (wr_dat & wbit) | (~wr_dat & dat_ff); // see [RULE3]
  assign nxt_dir = (wr_dir & wbit) | (~wr_dir & dir_ff); // see [RULE2]

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      dat_ff <= bpw_pkg::RST_DATA; // see [RULE6] see [RULE7]
      dir_ff <= bpw_pkg::RST_DIR; // see [RULE6]
    end else begin
      dat_ff <= nxt_dat;
      dir_ff <= nxt_dir;
    end
  end

  // read answer captured in the access cycle, no input latching beyond it
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      rd_data_ff <= bpw_pkg::RST_RDATA;
    end else if (do_rd) begin
      rd_data_ff <= rd_mux; // see [RULE4]
    end
  end

  // pull-high follows the option but only on pins set as input
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      pull_ff <= '0;
    end else begin
      pull_ff <= pull_opt & nxt_dir; // see [RULE9]
    end
  end

  // wake-up
  wire [7:0] cur_a = pin_sync[7:0];
  wire [7:0] fall_a = prev_a_ff & ~cur_a & wake_opt; // see [RULE10]
  wire [1:0] axis_edge = (prev_a_ff[5:4] ^ cur_a[5:4]) & wake_opt[5:4] & axis_both_opt; // see [RULE12]
  wire [1:0] axis_hit = fall_a[5:4] | axis_edge;
  wire wake_any = (|fall_a) | (|axis_edge);
  wire halted = (state_ff == bpw_pkg::BPW_HALT);

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      prev_a_ff <= bpw_pkg::RST_PINS[7:0];
    end else begin
      prev_a_ff <= cur_a;
    end
  end

  always_comb begin
    nxt_state = state_ff;
    unique case (state_ff)
      bpw_pkg::BPW_RUN: begin
        if (halt_req) begin
          nxt_state = bpw_pkg::BPW_HALT;
        end
      end
      bpw_pkg::BPW_HALT: begin
        if (wake_any) begin
          nxt_state = bpw_pkg::BPW_WAKE; // see [RULE10] see [RULE11]
        end
      end
      bpw_pkg::BPW_WAKE: begin
        nxt_state = bpw_pkg::BPW_RUN;
      end
      default: begin
        nxt_state = bpw_pkg::BPW_RUN;
      end
    endcase
  end

  // the core clock gate only opens again through a wake edge or a reset
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      state_ff <= bpw_pkg::BPW_RUN;
      pd_ff <= 1'b0;
      run_ff <= 1'b1;
      wake_ff <= 1'b0;
    end else begin
      state_ff <= nxt_state;
      pd_ff <= (nxt_state == bpw_pkg::BPW_HALT); // see [RULE11]
      run_ff <= (nxt_state == bpw_pkg::BPW_RUN); // see [RULE11]
      wake_ff <= (nxt_state == bpw_pkg::BPW_WAKE);
    end
  end

  // axis flags: set wins over a clearing read in the same cycle
  wire flag_clr = do_rd & hit_flag; // see [RULE14]
  wire [1:0] flag_set = axis_hit & {2{halted}}; // see [RULE13] see [RULE17]
  assign nxt_flag = flag_set | (flag_ff & ~{2{flag_clr}});

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      flag_ff <= bpw_pkg::RST_FLAGS; // see [RULE17]
    end else begin
      flag_ff <= nxt_flag;
    end
  end

  // outputs
  assign rd_data = rd_data_ff;
  assign pin_out = dat_ff;
  // enable is active low, so a one in direction releases the pin
  assign pin_oe_b = dir_ff; // see [RULE2]
  assign pull_on = pull_ff;
  // raw synchronised level; the timer mode is software's choice
  assign timer_event_input = pin_sync[bpw_pkg::PIN_TIMER];
  assign power_down = pd_ff;
  assign clk_run = run_ff;
  assign wake_pulse = wake_ff;
  assign axis_flags = flag_ff;

  // assertions
  wire pa_wr = do_wr & hit_dat[0];
  wire pa_rd = do_rd & hit_dat[0];

  a_dir_write: // see [RULE2]
  assert property (@(posedge clk) disable iff (!rst_b)
    (do_wr & hit_dir[0] & !cmd.bit_op) |=> (pin_oe_b[7:0] == $past(cmd.wdata)))
  else $error("direction write not reflected on enables");

  a_latch_hold: // see [RULE3]
  assert property (@(posedge clk) disable iff (!rst_b)
    !pa_wr |=> $stable(pin_out[7:0]))
  else $error("port A latch changed without a write");

  a_input_live: // see [RULE4]
  assert property (@(posedge clk) disable iff (!rst_b)
    pa_rd |=> ((rd_data ^ $past(pin_sync[7:0])) & $past(dir_ff[7:0])) == 8'h00)
  else $error("input pin read does not match sampled level");

  a_output_read: // see [RULE5]
  assert property (@(posedge clk) disable iff (!rst_b)
    pa_rd |=> ((rd_data ^ $past(pin_out[7:0])) & ~$past(pin_oe_b[7:0])) == 8'h00)
  else $error("output pin read does not return latch");

  a_rmw_set: // see [RULE8]
  assert property (@(posedge clk) disable iff (!rst_b)
    (pa_wr & cmd.bit_op & cmd.bit_set) |=> pin_out[$past(cmd.bit_sel)])
  else $error("bit set did not land in port A latch");

  a_pull_input: // see [RULE9]
  assert property (@(posedge clk) disable iff (!rst_b)
    (pull_on & ~pin_oe_b) == 17'h00000)
  else $error("pull-high on an output pin");

  a_wake_exit: // see [RULE10]
  assert property (@(posedge clk) disable iff (!rst_b)
    (halted & wake_any) |=> wake_pulse ##1 (clk_run & !power_down))
  else $error("wake edge did not restart the clock");

  a_halt_stay: // see [RULE11]
  assert property (@(posedge clk) disable iff (!rst_b)
    (halted & !wake_any) |=> (power_down & !clk_run))
  else $error("left power-down without a wake edge");

  a_axis_set: // see [RULE13]
  assert property (@(posedge clk) disable iff (!rst_b)
    (halted & axis_hit[0]) |=> axis_flags[0])
  else $error("axis wake did not set its flag");

  a_flag_clear: // see [RULE14]
  assert property (@(posedge clk) disable iff (!rst_b)
    (flag_clr & !halted) |=> (axis_flags == 2'h0))
  else $error("flag read did not clear axis flags");

  a_flag_run: // see [RULE17]
  assert property (@(posedge clk) disable iff (!rst_b)
    $rose(axis_flags[1]) |-> $past(state_ff) == bpw_pkg::BPW_HALT)
  else $error("axis flag set outside power-down");

  a_flag_run0: // see [RULE17]
  assert property (@(posedge clk) disable iff (!rst_b)
    $rose(axis_flags[0]) |-> $past(state_ff) == bpw_pkg::BPW_HALT)
  else $error("first axis flag set outside power-down");

  a_axis2_set: // see [RULE13]
  assert property (@(posedge clk) disable iff (!rst_b)
    (halted & axis_hit[1]) |=> axis_flags[1])
  else $error("second axis wake did not set its flag");

  a_axis_both: // see [RULE12]
  assert property (@(posedge clk) disable iff (!rst_b)
    (halted & (|(wake_opt[5:4] & axis_both_opt & cur_a[5:4] & ~$past(cur_a[5:4]))))
    |=> wake_pulse)
  else $error("rising axis edge did not wake");

  a_sb_read: // see [RULE1]
  assert property (@(posedge clk) disable iff (!rst_b)
    (do_rd & (|hit_dat[16:8])) |=> (rd_data[7:1] == 7'h00))
  else $error("single-bit read set upper bits");

endmodule : bpw_port

`default_nettype wire

// ===== tb/bpw_sw.sv
`timescale 1ns/100ps
`default_nettype none
module bpw_sw (
  input wire logic clk,
  input wire logic [16:0] pin_out,
  input wire logic [16:0] pin_oe_b,
  input wire logic [16:0] pull_on,
  input wire logic [16:0] sw_en,
  input wire logic [16:0] sw_val,
  output logic [16:0] pin_in
);
  logic flt_ff = 1'b0;
  // an open line with no pull wanders, so nothing may lean on its last level
  always @(posedge clk) begin
    flt_ff <= ~flt_ff;
  end
  // switch levels move only between reads, never near the sample point
  assign pin_in = (~pin_oe_b & pin_out) | (pin_oe_b & sw_en & sw_val)
    | (pin_oe_b & ~sw_en & (pull_on | {17{flt_ff}}));
endmodule : bpw_sw
`default_nettype wire

// ===== tb/tb.sv
`timescale 1ns/100ps
`default_nettype none
module tb;
  logic clk = 1'b0;
  logic rst_b = 1'b0;
  bpw_pkg::bpw_cmd_t cmd = '0;
  logic halt_req = 1'b0;
  logic [16:0] pull_opt = 17'h0;
  logic [16:0] sw_val = 17'h1ffff;
  logic [16:0] exp_dir = 17'h1ffff;
  logic [7:0] wake_opt = 8'h31;
  logic [1:0] axis_both_opt = 2'h1;
  logic [16:0] pin_in, pin_out, pin_oe_b, pull_on;
  logic [7:0] rd_data;
  logic [1:0] axis_flags;
  logic timer_event_input, power_down, clk_run, wake_pulse;
  logic [31:0] lfsr_ff = 32'hfb2b307f;
  int err_total = 0;
  int total_checks = 0;

  always #20 clk = ~clk;

  bpw_port dut_u (.clk(clk), .rst_b(rst_b), .cmd(cmd), .halt_req(halt_req),
    .pin_in(pin_in), .pull_opt(pull_opt), .wake_opt(wake_opt),
    .axis_both_opt(axis_both_opt), .rd_data(rd_data), .pin_out(pin_out),
    .pin_oe_b(pin_oe_b), .pull_on(pull_on), .timer_event_input(timer_event_input),
    .power_down(power_down), .clk_run(clk_run), .wake_pulse(wake_pulse),
    .axis_flags(axis_flags));

  bpw_sw sw_u (.clk(clk), .pin_out(pin_out), .pin_oe_b(pin_oe_b), .pull_on(pull_on),
    .sw_en(17'h1ffff), .sw_val(sw_val), .pin_in(pin_in));

  function automatic logic [31:0] rnd();
    lfsr_ff = {lfsr_ff[30:0], lfsr_ff[31] ^ lfsr_ff[21] ^ lfsr_ff[1] ^ lfsr_ff[0]};
    return lfsr_ff;
  endfunction : rnd

  // input pins show the switch, output pins show the latch
  function automatic logic [7:0] exp_rd(logic [7:0] dir, logic [7:0] lat, logic [7:0] pin);
    return (dir & pin) | (~dir & lat);
  endfunction : exp_rd

  task automatic final_report();
    if (err_total == 0 && total_checks > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask : final_report

  task automatic chk(logic [16:0] g, logic [16:0] e, string m);
    total_checks++;
    if (g !== e) begin
      err_total++;
      $display("[ERR] %0t %s got %h exp %h", $time, m, g, e);
    end
  endtask : chk

  task automatic cyc(int n);
    repeat (n) @(posedge clk);
    #1;
  endtask : cyc

  task automatic acc(logic w, logic r, logic b, logic s, logic [2:0] k, logic [7:0] a,
                     logic [7:0] d);
    cmd = {w, r, b, s, k, a, d};
    cyc(1);
    cmd = '0;
    cyc(1);
  endtask : acc

  task automatic halt();
    halt_req = 1'b1;
    cyc(1);
    halt_req = 1'b0;
  endtask : halt

  task automatic wait_wake();
    int n = 0;
    while (wake_pulse !== 1'b1) begin
      cyc(1);
      n++;
      if (n > 12) begin
        chk(17'h0, 17'h1, "wake timeout");
        final_report();
      end
    end
  endtask : wait_wake

  initial begin
    logic [31:0] r;
    logic [7:0] dir, e, ad, ac;
    r = rnd();
    pull_opt = r[16:0];
    cyc(2);
    chk(pin_out, bpw_pkg::RST_DATA, "rst data");
    chk(pin_oe_b, bpw_pkg::RST_DIR, "rst dir");
    chk({power_down, clk_run, axis_flags}, 17'h4, "rst pwr");
    rst_b = 1'b1;
    cyc(3);
    acc(1, 0, 0, 0, 0, bpw_pkg::ADDR_PA_DIR, 8'h00);
    exp_dir[7:0] = 8'h00;
    chk(pin_out, bpw_pkg::RST_DATA, "out before write");
    for (int i = 0; i < 8; i++) begin
      r = rnd();
      dir = r[23:16];
      sw_val[7:0] = r[15:8];
      acc(1, 0, 0, 0, 0, bpw_pkg::ADDR_PA_DIR, dir);
      acc(1, 0, 0, 0, 0, bpw_pkg::ADDR_PA_DAT, r[7:0]);
      exp_dir[7:0] = dir;
      cyc(2);
      chk(pin_out[7:0], r[7:0], "latch a");
      chk(pin_oe_b, exp_dir, "dir a");
      chk(pull_on, pull_opt & exp_dir, "pull");
      e = exp_rd(dir, r[7:0], r[15:8]);
      acc(0, 1, 0, 0, 0, bpw_pkg::ADDR_PA_DAT, 8'h00);
      chk(rd_data, e, "read a");
      chk(timer_event_input, e[2], "timer pin");
      acc(0, 0, 1, r[27], r[26:24], bpw_pkg::ADDR_PA_DAT, 8'h00);
      e[r[26:24]] = r[27];
      chk(pin_out[7:0], e, "bit op");
    end
    for (int i = 0; i < 9; i++) begin
      r = rnd();
      sw_val[8+i] = r[0];
      ad = (i < 7) ? bpw_pkg::ADDR_PB_DAT + 8'(i) : bpw_pkg::ADDR_PD_DAT + 8'(i - 7);
      ac = (i < 7) ? bpw_pkg::ADDR_PB_DIR + 8'(i) : bpw_pkg::ADDR_PD_DIR + 8'(i - 7);
      acc(1, 0, 0, 0, 0, ac, {7'h0, r[1]});
      acc(1, 0, 0, 0, 0, ad, {7'h0, r[2]});
      exp_dir[8+i] = r[1];
      cyc(2);
      acc(0, 1, 0, 0, 0, ad, 8'h00);
      chk(rd_data, {7'h00, r[1] ? r[0] : r[2]}, "read bit");
      chk(pin_oe_b, exp_dir, "dir bit");
      chk(pin_out[8+i], r[2], "latch bit");
    end
    acc(1, 0, 0, 0, 0, bpw_pkg::ADDR_PA_DIR, 8'hff);
    sw_val[7:0] = 8'hff;
    cyc(3);
    halt();
    chk({power_down, clk_run}, 17'h2, "halted");
    acc(1, 0, 0, 0, 0, bpw_pkg::ADDR_PA_DAT, ~e);
    chk(pin_out[7:0], e, "write in halt");
    sw_val[1] = 1'b0;
    cyc(6);
    chk(power_down, 17'h1, "unselected pin");
    sw_val[0] = 1'b0;
    wait_wake();
    chk({power_down, axis_flags}, 17'h0, "wake a0");
    cyc(1);
    chk(clk_run, 17'h1, "clock back");
    sw_val[1:0] = 2'b11;
    for (int k = 0; k < 2; k++) begin
      sw_val[4+k] = (k == 1);
      cyc(5);
      chk(axis_flags, 17'h0, "flag in run");
      halt();
      sw_val[4+k] = ~sw_val[4+k];
      wait_wake();
      chk(axis_flags, 17'h1 << k, "axis flag");
      cyc(2);
      acc(0, 1, 0, 0, 0, bpw_pkg::ADDR_FLAG, 8'h00);
      chk(rd_data, 17'h40 << k, "flag read");
      chk(axis_flags, 17'h0, "flag clear");
    end
    halt();
    sw_val[5] = 1'b1;
    cyc(6);
    chk(power_down, 17'h1, "rise without option");
    sw_val[4] = 1'b0;
    wait_wake();
    chk(axis_flags, 17'h1, "falling axis one");
    axis_both_opt = 2'h3;
    sw_val[5] = 1'b0;
    cyc(5);
    chk(axis_flags, 17'h1, "flag kept in run");
    halt();
    sw_val[5] = 1'b1;
    wait_wake();
    chk(axis_flags, 17'h3, "rising axis two");
    cyc(1);
    halt();
    rst_b = 1'b0;
    cyc(2);
    chk(pin_out, bpw_pkg::RST_DATA, "rst2 data");
    chk(pin_oe_b, bpw_pkg::RST_DIR, "rst2 dir");
    rst_b = 1'b1;
    cyc(2);
    chk({power_down, clk_run, axis_flags}, 17'h4, "rst2 pwr");
    final_report();
  end
endmodule : tb
`default_nettype wire
